// ==== bmrd_decoder.sv ====
// What this block does
// - after reset the 8 KB boot ROM repeats 32 times up to 0x0003_FFFF.
// - reset map puts flash bank 1 at 0x0004_0000, bank 2 at 0x0004_8000.
// - normal map puts chosen bank at 0, other at 0x8000; data memories unmoved.
// - in the normal map boot ROM answers only at 0x0002_0000 for 8 KB.
// - each peripheral is selected through a fixed address window; entries 23 and 24 share one window.
// - every reset starts execution in boot ROM before any flash code.
// - checksum first 2 kB of each bank; on pass run that bank from 0.
// - if short checksums fail, run further full-bank checksums before branching.
// - with no valid checksum, boot stays in control serving host memory commands.
`timescale 1ns/1ns
`default_nettype none
module bmrd_decoder #(
  parameter int SHORT_WORDS = bmrd_pkg::CHK_SHORT_BYTES / 4,
  parameter int FULL_WORDS = bmrd_pkg::CHK_FULL_BYTES / 4
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // processor bus request
  input wire bmrd_pkg::bmrd_req_type cpu_req,
  // host memory command while boot keeps control
  input wire bmrd_pkg::bmrd_req_type host_req,
  input wire logic host_start,
  input wire logic host_bank,
  // flash read port used by the boot checksum
  output logic chk_req,
  output logic chk_bank,
  output logic [12:0] chk_word,
  input wire logic [31:0] chk_data,
  input wire logic chk_ack,
  // decoded access
  output bmrd_pkg::bmrd_dec_type dec,
  output logic [bmrd_pkg::PERIPH_N-1:0] periph_sel,
  output logic decode_err,
  // map and boot status
  output logic map_normal,
  output logic map_swap,
  output logic host_mode,
  output logic boot_done
);
  bmrd_pkg::bmrd_map_type map;
  logic remap_go;
  logic remap_swap;

  // true when addr lies in [base, base+size-1]
  function automatic logic in_win(input logic [31:0] addr, input logic [31:0] base,
                                  input logic [31:0] size);
    in_win = (addr >= base) && (addr <= base + size - 32'h1);
  endfunction

  // offset mask for each target
  function automatic logic [bmrd_pkg::OFS_W-1:0] ofs_mask(input bmrd_pkg::bmrd_tgt_type t);
    case (t)
      bmrd_pkg::TGT_ROM: ofs_mask = bmrd_pkg::OFS_W'(bmrd_pkg::ROM_SIZE - 32'h1);
      bmrd_pkg::TGT_FLASH1,
      bmrd_pkg::TGT_FLASH2: ofs_mask = bmrd_pkg::OFS_W'(bmrd_pkg::FLASH_SIZE - 32'h1);
      bmrd_pkg::TGT_DFLASH: ofs_mask = bmrd_pkg::OFS_W'(bmrd_pkg::DFL_SIZE - 32'h1);
      bmrd_pkg::TGT_RAM: ofs_mask = bmrd_pkg::OFS_W'(bmrd_pkg::RAM_SIZE - 32'h1);
      bmrd_pkg::TGT_PERIPH: ofs_mask = 15'h00FF;
      default: ofs_mask = 15'h0000;
    endcase
  endfunction

  // boot sequencer drives the checksum walk and the map switch
  bmrd_boot_seq #(
    .SHORT_WORDS(SHORT_WORDS),
    .FULL_WORDS(FULL_WORDS)
  ) u_seq (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .rd_req(chk_req),
    .rd_bank(chk_bank),
    .rd_word(chk_word),
    .rd_data(chk_data),
    .rd_ack(chk_ack),
    .host_start(host_start),
    .host_bank(host_bank),
    .remap_go(remap_go),
    .remap_swap(remap_swap),
    .host_mode(host_mode),
    .boot_done(boot_done)
  );

  // request source: host commands reach all memory while boot holds control
  wire bmrd_pkg::bmrd_req_type req = host_mode ? host_req : cpu_req;
  wire [31:0] a = req.addr;

  // reset-state memory windows
  wire rst_rom = (a <= bmrd_pkg::RST_ROM_LAST);
  wire rst_fl1 = in_win(a, bmrd_pkg::RST_FL1_BASE, bmrd_pkg::FLASH_SIZE);
  wire rst_fl2 = in_win(a, bmrd_pkg::RST_FL2_BASE, bmrd_pkg::FLASH_SIZE);

  // normal-operation memory windows
  wire nrm_low = in_win(a, bmrd_pkg::NRM_LOW_BASE, bmrd_pkg::FLASH_SIZE);
  wire nrm_high = in_win(a, bmrd_pkg::NRM_HIGH_BASE, bmrd_pkg::FLASH_SIZE);
  wire nrm_rom = in_win(a, bmrd_pkg::NRM_ROM_BASE, bmrd_pkg::ROM_SIZE);

  // data memories sit at the same place in both maps
  wire hit_dfl = in_win(a, bmrd_pkg::DFL_BASE, bmrd_pkg::DFL_SIZE);
  wire hit_ram = in_win(a, bmrd_pkg::RAM_BASE, bmrd_pkg::RAM_SIZE);

  // peripheral window compare, one per block
  logic [bmrd_pkg::PERIPH_N-1:0] next_periph;
  genvar gi;
  generate
    for (gi = 0; gi < bmrd_pkg::PERIPH_N; gi++) begin : g_periph
      assign next_periph[gi] = (a >= bmrd_pkg::PERIPH_BASE[gi]) &&
                               (a <= bmrd_pkg::PERIPH_LAST[gi]);
    end
  endgenerate
  wire hit_periph = |next_periph;

  // flash banks as seen in the normal map
  wire bmrd_pkg::bmrd_tgt_type low_bank = map.swap ? bmrd_pkg::TGT_FLASH2 : bmrd_pkg::TGT_FLASH1;
  wire bmrd_pkg::bmrd_tgt_type high_bank = map.swap ? bmrd_pkg::TGT_FLASH1 : bmrd_pkg::TGT_FLASH2;

  // target select against the one registered map word
  wire bmrd_pkg::bmrd_tgt_type rst_tgt =
    rst_rom ? bmrd_pkg::TGT_ROM :
    rst_fl1 ? bmrd_pkg::TGT_FLASH1 :
    rst_fl2 ? bmrd_pkg::TGT_FLASH2 : bmrd_pkg::TGT_NONE;
  wire bmrd_pkg::bmrd_tgt_type nrm_tgt =
    nrm_low ? low_bank :
    nrm_high ? high_bank :
    nrm_rom ? bmrd_pkg::TGT_ROM : bmrd_pkg::TGT_NONE;
  wire bmrd_pkg::bmrd_tgt_type mem_tgt = map.normal ? nrm_tgt : rst_tgt;
  wire bmrd_pkg::bmrd_tgt_type next_tgt =
    (mem_tgt != bmrd_pkg::TGT_NONE) ? mem_tgt :
    hit_dfl ? bmrd_pkg::TGT_DFLASH :
    hit_ram ? bmrd_pkg::TGT_RAM :
    hit_periph ? bmrd_pkg::TGT_PERIPH : bmrd_pkg::TGT_NONE;
  wire [bmrd_pkg::OFS_W-1:0] next_ofs = a[bmrd_pkg::OFS_W-1:0] & ofs_mask(next_tgt);
  wire next_err = req.valid && (next_tgt == bmrd_pkg::TGT_NONE);

  // map word: both fields change on one edge after the checksum decision
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      map <= bmrd_pkg::MAP_RESET;
    end else if (remap_go) begin
      map <= '{normal: 1'b1, swap: remap_swap};
    end
  end

  // registered decode result, one cycle after the request
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      dec <= '0;
      periph_sel <= '0;
      decode_err <= 1'b0;
    end else begin
      dec.valid <= req.valid && !next_err;
      dec.wr <= req.wr;
      dec.tgt <= next_tgt;
      dec.offset <= next_ofs;
      dec.wdata <= req.wdata;
      periph_sel <= req.valid ? next_periph : '0;
      decode_err <= next_err;
    end
  end

  // map state shown to the system
  assign map_normal = map.normal;
  assign map_swap = map.swap;
endmodule
`default_nettype wire

// ==== bmrd_pkg.sv ====
`default_nettype none
package bmrd_pkg;
  // memory regions in both maps
  localparam logic [31:0] RST_ROM_LAST = 32'h0003_FFFF;
  localparam logic [31:0] RST_FL1_BASE = 32'h0004_0000;
  localparam logic [31:0] RST_FL2_BASE = 32'h0004_8000;
  localparam logic [31:0] NRM_LOW_BASE = 32'h0000_0000;
  localparam logic [31:0] NRM_HIGH_BASE = 32'h0000_8000;
  localparam logic [31:0] NRM_ROM_BASE = 32'h0002_0000;
  localparam logic [31:0] DFL_BASE = 32'h0006_8800;
  localparam logic [31:0] RAM_BASE = 32'h0006_9000;
  // region sizes in bytes
  localparam logic [31:0] ROM_SIZE = 32'h0000_2000;
  localparam logic [31:0] FLASH_SIZE = 32'h0000_8000;
  localparam logic [31:0] DFL_SIZE = 32'h0000_0800;
  localparam logic [31:0] RAM_SIZE = 32'h0000_1000;
  // checksum spans in bytes
  localparam int CHK_SHORT_BYTES = 2048;
  localparam int CHK_FULL_BYTES = 32768;
  localparam int OFS_W = 15;
  // peripheral windows, first and last byte
  localparam int PERIPH_N = 25;
  localparam logic [31:0] PERIPH_BASE [PERIPH_N] = '{
    32'h0012_0000, 32'h0013_0000, 32'h0014_0000, 32'h0015_0000, 32'h0016_0000,
    32'h0017_0000, 32'h0018_0000, 32'h0019_0000, 32'h001A_0000, 32'h001B_0000,
    32'h001C_0000, 32'h001D_0000, 32'h001E_0000, 32'hFFF7_EC00, 32'hFFF7_ED00,
    32'hFFF7_F000, 32'hFFF7_F600, 32'hFFF7_FA00, 32'hFFF7_FD00, 32'hFFFF_FD00,
    32'hFFFF_FE00, 32'hFFFF_FF20, 32'hFFFF_FF40, 32'hFFFF_FFD0, 32'hFFFF_FFD0};
  localparam logic [31:0] PERIPH_LAST [PERIPH_N] = '{
    32'h0012_00FF, 32'h0013_00FF, 32'h0014_00FF, 32'h0015_00FF, 32'h0016_00FF,
    32'h0017_00FF, 32'h0018_00FF, 32'h0019_00FF, 32'h001A_00FF, 32'h001B_00FF,
    32'h001C_00FF, 32'h001D_00FF, 32'h001E_00FF, 32'hFFF7_ECFF, 32'hFFF7_EDFF,
    32'hFFF7_F0FF, 32'hFFF7_F6FF, 32'hFFF7_FAFF, 32'hFFF7_FDFF, 32'hFFFF_FDFF,
    32'hFFFF_FEFF, 32'hFFFF_FF37, 32'hFFFF_FF50, 32'hFFFF_FFEC, 32'hFFFF_FFEC};
  // decode targets
  typedef enum logic [2:0] {
    TGT_NONE, TGT_ROM, TGT_FLASH1, TGT_FLASH2, TGT_DFLASH, TGT_RAM, TGT_PERIPH
  } bmrd_tgt_type;
  // bus request from a master
  typedef struct packed {
    logic valid;
    logic wr;
    logic [31:0] addr;
    logic [31:0] wdata;
  } bmrd_req_type;
  // decoded access towards the memories
  typedef struct packed {
    logic valid;
    logic wr;
    bmrd_tgt_type tgt;
    logic [OFS_W-1:0] offset;
    logic [31:0] wdata;
  } bmrd_dec_type;
  // memory map state, switched as one word
  typedef struct packed {
    logic normal;
    logic swap;
  } bmrd_map_type;
  localparam bmrd_map_type MAP_RESET = '{normal: 1'b0, swap: 1'b0};
endpackage
`default_nettype wire

// ==== bmrd_boot_seq.sv ====
`timescale 1ns/1ns
`default_nettype none
module bmrd_boot_seq #(
  parameter int SHORT_WORDS = bmrd_pkg::CHK_SHORT_BYTES / 4,
  parameter int FULL_WORDS = bmrd_pkg::CHK_FULL_BYTES / 4
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // flash read port for checksums
  output logic rd_req,
  output logic rd_bank,
  output logic [12:0] rd_word,
  input wire logic [31:0] rd_data,
  input wire logic rd_ack,
  // host start command while the boot code keeps control
  input wire logic host_start,
  input wire logic host_bank,
  // map switch request
  output logic remap_go,
  output logic remap_swap,
  output logic host_mode,
  output logic boot_done
);
  typedef enum logic [2:0] {S_READ, S_CHECK, S_HOST, S_REMAP, S_DONE} bmrd_st_type;
  bmrd_st_type state;
  logic [1:0] phase; // bit1 full span, bit0 bank
  logic [31:0] sum;
  logic pass;
  logic bank_sel;
  wire [12:0] last_word = phase[1] ? 13'(FULL_WORDS - 1) : 13'(SHORT_WORDS - 1);
  wire at_last = (rd_word == last_word);

  // handshake outputs from state
  assign rd_req = (state == S_READ);
  assign rd_bank = phase[0];
  assign remap_go = (state == S_REMAP);
  assign remap_swap = bank_sel;
  assign host_mode = (state == S_HOST);
  assign boot_done = (state == S_DONE);

  // checksum walk: sum of all words but the last must equal the last
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= S_READ;
      phase <= 2'h0;
      sum <= 32'h0;
      pass <= 1'b0;
      bank_sel <= 1'b0;
      rd_word <= 13'h0;
    end else begin
      case (state)
        S_READ: begin
          if (rd_ack) begin
            if (at_last) begin
              pass <= (sum == rd_data);
              state <= S_CHECK;
            end else begin
              sum <= sum + rd_data;
              rd_word <= rd_word + 13'h1;
            end
          end
        end
        S_CHECK: begin
          sum <= 32'h0;
          rd_word <= 13'h0;
          if (pass) begin
            bank_sel <= phase[0];
            state <= S_REMAP;
          end else if (phase == 2'h3) begin
            state <= S_HOST;
          end else begin
            phase <= phase + 2'h1;
            state <= S_READ;
          end
        end
        S_HOST: begin
          if (host_start) begin
            bank_sel <= host_bank;
            state <= S_REMAP;
          end
        end
        S_REMAP: state <= S_DONE;
        S_DONE: state <= S_DONE;
        default: state <= S_READ;
      endcase
    end
  end
endmodule
`default_nettype wire

// ==== bmrd_properties.sv ====
`timescale 1ns/1ns
`default_nettype none
module bmrd_properties (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // request and decode
  input wire bmrd_pkg::bmrd_req_type cpu_req,
  input wire bmrd_pkg::bmrd_dec_type dec,
  input wire logic [bmrd_pkg::PERIPH_N-1:0] periph_sel,
  input wire logic decode_err,
  // map state
  input wire logic map_normal,
  input wire logic map_swap,
  input wire logic boot_done,
  input wire logic host_mode
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // request fields seen by the decoder
  wire logic tk = cpu_req.valid && !host_mode;
  wire logic [31:0] a = cpu_req.addr;
  wire logic [14:0] lo = cpu_req.addr[14:0];
  wire logic hi = cpu_req.addr[15];
  // map leaves the reset layout
  sequence s_switch;
    !map_normal ##1 map_normal;
  endsequence
  a_rom_repeat: assert property (tk && !map_normal && a < 32'h0004_0000 |=>
    dec.tgt == bmrd_pkg::TGT_ROM && dec.offset == ($past(lo) & 15'h1FFF)) else $error("rom alias");
  a_flash_reset: assert property (tk && !map_normal && a[31:16] == 16'h0004 |=>
    dec.tgt == ($past(hi) ? bmrd_pkg::TGT_FLASH2 : bmrd_pkg::TGT_FLASH1) && dec.offset == $past(lo))
    else $error("reset flash");
  a_low_bank: assert property (tk && map_normal && a[31:16] == 16'h0000 |=>
    dec.tgt == (($past(hi) ^ $past(map_swap)) ? bmrd_pkg::TGT_FLASH2 : bmrd_pkg::TGT_FLASH1))
    else $error("low bank");
  a_data_ram: assert property (tk && a[31:12] == 20'h00069 |=>
    dec.tgt == bmrd_pkg::TGT_RAM && dec.offset == ($past(lo) & 15'h0FFF)) else $error("ram");
  a_rom_single: assert property (tk && map_normal && a[31:13] == 19'h00010 |=>
    dec.tgt == bmrd_pkg::TGT_ROM && dec.offset == ($past(lo) & 15'h1FFF)) else $error("rom");
  a_rom_gone: assert property (tk && map_normal && a[31:16] == 16'h0003 |=>
    decode_err && !dec.valid) else $error("rom alias left");
  a_uart_window: assert property (tk && a[31:8] == 24'hFFF7EC |=>
    periph_sel == 25'h000_2000 && dec.tgt == bmrd_pkg::TGT_PERIPH) else $error("uart window");
  a_boot_first: assert property (s_switch |-> ##[0:1] boot_done) else $error("flash map early");
  a_map_atomic: assert property (map_swap |-> map_normal) else $error("swap alone");
  a_map_kept: assert property (map_normal |=> map_normal && $stable(map_swap)) else $error("map");
endmodule
`default_nettype wire

// ==== bmrd_flash_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module bmrd_flash_model (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // checksum read port
  input wire logic chk_req,
  input wire logic chk_bank,
  input wire logic [12:0] chk_word,
  output logic [31:0] chk_data,
  output logic chk_ack,
  // image kind per bank: 0 bad, 1 short image good, 2 full image good
  input wire logic [1:0] mode1,
  input wire logic [1:0] mode2
);
  logic slow;
  logic [1:0] m;
  logic [31:0] word;
  assign m = chk_bank ? mode2 : mode1;
  // word i holds i+1; sum words sit at 3 and 7
  always_comb begin
    word = {19'h0, chk_word} + 32'h1;
    if (chk_word == 13'h3) word = (m == 2'h1) ? 32'h6 : 32'h0;
    if (chk_word == 13'h7) word = (m == 2'h2) ? 32'h18 : 32'h0;
  end
  // answers on alternate cycles; data is garbage outside the ack
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      slow <= 1'b0;
      chk_ack <= 1'b0;
      chk_data <= 32'h0;
    end else begin
      slow <= ~slow;
      chk_ack <= chk_req && !chk_ack && slow;
      chk_data <= (chk_req && !chk_ack && slow) ? word : ~word;
    end
  end
endmodule
`default_nettype wire

// ==== test_boot_memory_remap_decoder.sv ====
`timescale 1ns/1ns
`default_nettype none
module test_boot_memory_remap_decoder;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  bmrd_pkg::bmrd_req_type req = '0;
  logic host_start = 1'b0;
  logic host_bank = 1'b0;
  logic [1:0] mode1 = 2'h0;
  logic [1:0] mode2 = 2'h0;
  logic chk_req, chk_bank, chk_ack, decode_err, map_normal, map_swap, host_mode, boot_done;
  logic [12:0] chk_word;
  logic [31:0] chk_data;
  logic [24:0] periph_sel;
  bmrd_pkg::bmrd_dec_type dec;
  int fail_count = 0;
  int checked = 0;
  always #25 ref_clk = ~ref_clk;
  // same request on both masters, the design picks one
  bmrd_decoder #(.SHORT_WORDS(4), .FULL_WORDS(8)) u_dut (.ref_clk, .rst_n, .cpu_req(req),
    .host_req(req), .host_start, .host_bank, .chk_req, .chk_bank, .chk_word, .chk_data,
    .chk_ack, .dec, .periph_sel, .decode_err, .map_normal, .map_swap, .host_mode, .boot_done);
  bmrd_flash_model u_flash (.ref_clk, .rst_n, .chk_req, .chk_bank, .chk_word, .chk_data,
    .chk_ack, .mode1, .mode2);
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic restart(input logic [1:0] m1, input logic [1:0] m2);
    @(posedge ref_clk);
    rst_n <= 1'b0;
    mode1 <= m1;
    mode2 <= m2;
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
  endtask
  task automatic wait_flag(input bit want_host);
    int n;
    n = 0;
    while ((want_host ? host_mode : boot_done) !== 1'b1 && n < 400) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    // a flag that never comes is a mismatch of its own
    if ((want_host ? host_mode : boot_done) !== 1'b1) begin
      fail_count++;
      $display("BAD %s expected 1 seen timeout", want_host ? "host_mode" : "boot_done");
    end
  endtask
  task automatic access(input logic [31:0] ad, input bmrd_pkg::bmrd_tgt_type t,
                        input logic [14:0] off, input logic [24:0] sel, input logic err);
    @(posedge ref_clk);
    req <= '{valid: 1'b1, wr: ad[2], addr: ad, wdata: ~ad};
    @(posedge ref_clk);
    req.valid <= 1'b0;
    #1;
    cmp("error", {31'h0, err}, {31'h0, decode_err});
    cmp("valid", {31'h0, !err}, {31'h0, dec.valid});
    cmp("select", {7'h0, sel}, {7'h0, periph_sel});
    cmp("write", {31'h0, ad[2]}, {31'h0, dec.wr});
    cmp("wdata", ~ad, dec.wdata);
    if (!err) begin
      cmp("target", {29'h0, t}, {29'h0, dec.tgt});
      cmp("offset", {17'h0, off}, {17'h0, dec.offset});
    end
  endtask
  task automatic t_reset_map;
    restart(2'h0, 2'h0);
    @(posedge ref_clk);
    #1;
    cmp("early map", 32'h0, {31'h0, map_normal});
    cmp("check start", 32'h1, {17'h0, chk_word, chk_bank, chk_req});
    access(32'h0003_E004, bmrd_pkg::TGT_ROM, 15'h0004, 25'h0, 1'b0);
    access(32'h0000_0010, bmrd_pkg::TGT_ROM, 15'h0010, 25'h0, 1'b0);
    access(32'h0004_0004, bmrd_pkg::TGT_FLASH1, 15'h0004, 25'h0, 1'b0);
    access(32'h0004_FFFC, bmrd_pkg::TGT_FLASH2, 15'h7FFC, 25'h0, 1'b0);
    access(32'h0006_8804, bmrd_pkg::TGT_DFLASH, 15'h0004, 25'h0, 1'b0);
    access(32'h0006_9FFC, bmrd_pkg::TGT_RAM, 15'h0FFC, 25'h0, 1'b0);
    access(32'h0012_0000, bmrd_pkg::TGT_PERIPH, 15'h0000, 25'h1, 1'b0);
    access(32'hFFF7_ECFF, bmrd_pkg::TGT_PERIPH, 15'h00FF, 25'h000_2000, 1'b0);
    access(32'h0010_0000, bmrd_pkg::TGT_NONE, 15'h0, 25'h0, 1'b1);
  endtask
  task automatic t_host;
    wait_flag(1'b1);
    cmp("host mode", 32'h1, {31'h0, host_mode});
    cmp("host map", 32'h0, {31'h0, boot_done | map_normal});
    access(32'h0000_2008, bmrd_pkg::TGT_ROM, 15'h0008, 25'h0, 1'b0);
    @(posedge ref_clk);
    host_start <= 1'b1;
    host_bank <= 1'b1;
    @(posedge ref_clk);
    host_start <= 1'b0;
    wait_flag(1'b0);
    cmp("host swap", 32'h3, {30'h0, map_normal, map_swap});
    access(32'h0000_0000, bmrd_pkg::TGT_FLASH2, 15'h0000, 25'h0, 1'b0);
  endtask
  task automatic t_short;
    restart(2'h1, 2'h0);
    wait_flag(1'b0);
    cmp("short map", 32'h2, {30'h0, map_normal, map_swap});
    cmp("check idle", 32'h0, {31'h0, chk_req});
    access(32'h0000_0004, bmrd_pkg::TGT_FLASH1, 15'h0004, 25'h0, 1'b0);
    access(32'h0000_8008, bmrd_pkg::TGT_FLASH2, 15'h0008, 25'h0, 1'b0);
    access(32'h0002_0008, bmrd_pkg::TGT_ROM, 15'h0008, 25'h0, 1'b0);
    access(32'h0003_E000, bmrd_pkg::TGT_NONE, 15'h0, 25'h0, 1'b1);
    access(32'h0004_0000, bmrd_pkg::TGT_NONE, 15'h0, 25'h0, 1'b1);
  endtask
  task automatic t_full;
    restart(2'h0, 2'h2);
    wait_flag(1'b0);
    cmp("full map", 32'h3, {30'h0, map_normal, map_swap});
    access(32'h0000_0010, bmrd_pkg::TGT_FLASH2, 15'h0010, 25'h0, 1'b0);
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // main sequence
  initial begin
    t_reset_map();
    t_host();
    t_short();
    t_full();
    finish_test();
  end
  // watchdog well beyond the expected run
  initial begin
    repeat (5000) @(posedge ref_clk);
    fail_count++;
    finish_test();
  end
endmodule
bind bmrd_decoder bmrd_properties u_props (.ref_clk, .rst_n, .cpu_req, .dec, .periph_sel,
  .decode_err, .map_normal, .map_swap, .boot_done, .host_mode);
`default_nettype wire
